// *** fbreg_core.sv ***
// process feedback regulator front end: shaping, combine, setpoint, P term
// assumes all inputs are synchronous to sys_clk; ctl_tick is a one-cycle enable
`timescale 1ns/100ps
module fbreg_core
  import fbreg_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic ctl_tick, // control tick enable
  input wire logic loop_closed_cfg, // configuration: 1 closed loop
  input wire logic start_cmd, // run request level
  input wire logic feedback_shaping_select,
  input wire logic [2:0] dual_input_combine_mode,
  input wire logic regulator_direction,
  input wire logic integrator_clamp_enable,
  input wire logic signed [VAL_W-1:0] loop_entry_frequency,
  input wire logic [GAIN_W-1:0] proportional_factor,
  input wire logic signed [VAL_W-1:0] bus_feedback_one,
  input wire logic signed [VAL_W-1:0] bus_feedback_two,
  input wire logic signed [VAL_W-1:0] analog_feedback_one,
  input wire logic signed [VAL_W-1:0] analog_feedback_two,
  input wire logic signed [VAL_W-1:0] setpoint_one,
  input wire logic signed [VAL_W-1:0] setpoint_two,
  input wire logic signed [VAL_W-1:0] ref_min,
  input wire logic signed [VAL_W-1:0] ref_max,
  input wire logic signed [VAL_W-1:0] remote_reference,
  input wire logic signed [VAL_W-1:0] ramp_frequency, // ramp generator output
  input wire logic signed [VAL_W-1:0] actual_frequency,
  input wire logic current_limit,
  input wire logic voltage_limit,
  input wire logic frequency_limit,
  output logic signed [VAL_W-1:0] feedback_value,
  output logic signed [VAL_W-1:0] resulting_reference,
  output logic signed [VAL_W-1:0] deviation,
  output logic signed [VAL_W-1:0] prop_term,
  output logic signed [VAL_W-1:0] frequency_demand,
  output logic regulator_active
);
  // ==================================================
  // state
  typedef struct packed {
    phase_e phase; // loop phase
    logic [2:0] mode; // accepted combine mode
    logic held; // disengaged after anti-windup clamp
    logic signed [VAL_W-1:0] fb; // effective feedback
    logic signed [VAL_W-1:0] rref; // resulting reference
    logic signed [VAL_W-1:0] dev; // deviation
    logic signed [VAL_W-1:0] prop; // proportional term
    logic signed [VAL_W+7:0] integ; // integrator, wide to carry windup
    logic signed [VAL_W-1:0] freq; // output demand
  } state_s;

  state_s st_reg;
  state_s st_next;

  // ==================================================
  // helpers
  // saturate a wide signed value into the value format
  function automatic logic signed [VAL_W-1:0] sat(input logic signed [VAL_W+15:0] v);
    if (v > 32'(VAL_MAX)) begin
      sat = VAL_MAX;
    end else if (v < 32'(VAL_MIN)) begin
      sat = VAL_MIN;
    end else begin
      sat = v[VAL_W-1:0];
    end
  endfunction : sat

  // integer square root in the value format; negative input reads as zero
  function automatic logic signed [VAL_W-1:0] fx_sqrt(input logic signed [VAL_W-1:0] v);
    logic [23:0] rad;
    logic [11:0] root;
    logic [11:0] trial;
    rad = (v < 0) ? 24'h000000 : {v[VAL_W-2:0], 9'h000} >> 1;
    root = 12'h000;
    for (int b = 11; b >= 0; b--) begin
      trial = root | (12'h001 << b);
      if (24'(trial) * 24'(trial) <= rad) begin
        root = trial;
      end
    end
    fx_sqrt = VAL_W'(root);
  endfunction : fx_sqrt

  // ==================================================
  // combinational datapath
  logic signed [VAL_W-1:0] ch1, ch2, fb1, fb2, sp1, sp2, e1, e2, dev_raw;
  logic signed [VAL_W-1:0] fb_sel, ref_base;
  logic limited;

  always_comb begin
    st_next = st_reg;
    // channels: bus value plus analog input, saturated
    ch1 = sat(32'(bus_feedback_one) + 32'(analog_feedback_one));
    ch2 = sat(32'(bus_feedback_two) + 32'(analog_feedback_two));
    // shaping per channel; square root applies to the summed bus plus analog value of each channel
    fb1 = (feedback_shaping_select == SHAPE_SQRT) ? fx_sqrt(ch1) : ch1;
    fb2 = (feedback_shaping_select == SHAPE_SQRT) ? fx_sqrt(ch2) : ch2;
    // setpoints held inside the reference window
    sp1 = (setpoint_one < ref_min) ? ref_min :
          (setpoint_one > ref_max) ? ref_max : setpoint_one;
    sp2 = (setpoint_two < ref_min) ? ref_min :
          (setpoint_two > ref_max) ? ref_max : setpoint_two;
    e1 = sat(32'(sp1) - 32'(fb1));
    e2 = sat(32'(sp2) - 32'(fb2));
    ref_base = sp1; // setpoint one is the default comparison base
    fb_sel = fb1;
    case (st_reg.mode)
      CMB_MIN: fb_sel = (fb1 < fb2) ? fb1 : fb2;
      CMB_MAX: fb_sel = (fb1 > fb2) ? fb1 : fb2;
      CMB_SUM: fb_sel = sat(32'(fb1) + 32'(fb2));
      CMB_DIFF: fb_sel = sat(32'(fb2) - 32'(fb1));
      CMB_AVG: fb_sel = VAL_W'((17'(fb1) + 17'(fb2)) >>> 1);
      CMB_ZLOW: begin
        // signed compare makes any positive error beat any negative one
        // zone two only counts in closed loop; open loop stays on setpoint one
        if (e2 > e1 && loop_closed_cfg == CFG_CLOSED) begin
          fb_sel = fb2;
          ref_base = sp2;
        end
      end
      CMB_ZHIGH: begin
        if (e2 < e1 && loop_closed_cfg == CFG_CLOSED) begin
          fb_sel = fb2;
          ref_base = sp2;
        end
      end
      default: fb_sel = (fb1 > fb2) ? fb1 : fb2;
    endcase
    // accept only legal mode codes; an illegal write keeps the last mode
    if (ctl_tick && dual_input_combine_mode <= CMB_ZHIGH) begin
      st_next.mode = dual_input_combine_mode;
    end
    // normal: error grows as feedback falls; inverse flips the sign in closed loop only
    dev_raw = sat(32'(ref_base) + 32'(remote_reference) - 32'(fb_sel));
    if (regulator_direction != DIR_NORMAL && loop_closed_cfg == CFG_CLOSED) begin
      dev_raw = sat(-32'(dev_raw));
    end
    limited = current_limit | voltage_limit | frequency_limit;

    if (ctl_tick) begin
      st_next.fb = fb_sel;
      st_next.rref = sat(32'(ref_base) + 32'(remote_reference));
      st_next.dev = dev_raw;
      case (st_reg.phase)
        PH_IDLE: begin
          st_next.freq = FREQ_RST;
          st_next.integ = '0;
          st_next.held = 1'b0;
          if (start_cmd) begin
            st_next.phase = PH_RAMP;
          end
        end
        PH_RAMP: begin
          // follow the ramp open loop; current limit holds us here
          st_next.freq = ramp_frequency;
          if (!start_cmd) begin
            st_next.phase = PH_IDLE;
          end else if (loop_closed_cfg == CFG_CLOSED && !current_limit &&
                       ramp_frequency >= loop_entry_frequency) begin
            st_next.phase = PH_CLOSED;
            st_next.integ = 24'(actual_frequency) <<< FRAC_W;
          end
        end
        PH_CLOSED: begin
          st_next.prop = sat(32'((40'(dev_raw) * 40'($signed({1'b0, proportional_factor})))
                             >>> FRAC_W));
          if (!start_cmd || loop_closed_cfg != CFG_CLOSED) begin
            st_next.phase = PH_IDLE;
          end else if (integrator_clamp_enable && limited) begin
            // track the real output so no windup builds up
            st_next.integ = 24'(actual_frequency) <<< FRAC_W;
            st_next.held = 1'b1;
          end else if (st_reg.held) begin
            // re-engage on zero deviation or sign change
            if (dev_raw == 0 || (dev_raw[VAL_W-1] != st_reg.dev[VAL_W-1])) begin
              st_next.held = 1'b0;
            end
          end else begin
            // keeps integrating while limited when clamp is off
            st_next.integ = st_reg.integ + 24'(dev_raw);
          end
          if (!(integrator_clamp_enable && limited)) begin
            st_next.freq = sat(32'(st_reg.integ >>> FRAC_W) + 32'(st_next.prop));
          end else begin
            st_next.freq = actual_frequency;
          end
        end
        default: st_next.phase = PH_IDLE;
      endcase
    end
  end

  // ==================================================
  // state register
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= '{phase: PH_IDLE, mode: CMB_RST, held: 1'b0, fb: '0, rref: '0,
                  dev: '0, prop: '0, integ: '0, freq: FREQ_RST};
    end else begin
      st_reg <= st_next;
    end
  end

  assign feedback_value = st_reg.fb;
  assign resulting_reference = st_reg.rref;
  assign deviation = st_reg.dev;
  assign prop_term = st_reg.prop;
  assign frequency_demand = st_reg.freq;
  assign regulator_active = (st_reg.phase == PH_CLOSED) && !st_reg.held;

  // ==================================================
  // checks
  a_mode_legal: assert property (@(posedge sys_clk) disable iff (!rstn)
    st_reg.mode <= CMB_ZHIGH) else $error("combine mode out of range");
  a_ramp_follow: assert property (@(posedge sys_clk) disable iff (!rstn)
    ctl_tick && st_reg.phase == PH_RAMP && start_cmd |=> frequency_demand == $past(ramp_frequency))
    else $error("ramp not followed");
  a_climit_blocks: assert property (@(posedge sys_clk) disable iff (!rstn)
    ctl_tick && st_reg.phase == PH_RAMP && current_limit |=> st_reg.phase != PH_CLOSED)
    else $error("closed loop entered at current limit");
  a_clamp_load: assert property (@(posedge sys_clk) disable iff (!rstn)
    ctl_tick && st_reg.phase == PH_CLOSED && start_cmd && loop_closed_cfg &&
    integrator_clamp_enable && limited |=> st_reg.held && frequency_demand == $past(actual_frequency))
    else $error("anti-windup did not load");
  a_held_idle: assert property (@(posedge sys_clk) disable iff (!rstn)
    st_reg.held |-> !regulator_active) else $error("regulator engaged while held");
  a_mode_max: assert property (@(posedge sys_clk) disable iff (!rstn)
    ctl_tick && st_reg.mode == CMB_MAX |=> feedback_value >= $past(fb1) && feedback_value >= $past(fb2))
    else $error("maximum mode wrong");
  a_mode_min: assert property (@(posedge sys_clk) disable iff (!rstn)
    ctl_tick && st_reg.mode == CMB_MIN |=> feedback_value <= $past(fb1) && feedback_value <= $past(fb2))
    else $error("minimum mode wrong");
  a_sp_window: assert property (@(posedge sys_clk) disable iff (!rstn)
    ref_min <= ref_max |-> sp1 >= ref_min && sp1 <= ref_max) else $error("setpoint outside");
  c_close: cover property (@(posedge sys_clk) disable iff (!rstn) st_reg.phase == PH_CLOSED);
  c_held: cover property (@(posedge sys_clk) disable iff (!rstn) st_reg.held);
  c_zone2: cover property (@(posedge sys_clk) disable iff (!rstn)
    st_reg.mode == CMB_ZLOW && e2 > e1);
endmodule : fbreg_core

// *** fbreg_pkg.sv ***
// package for the process feedback regulator front end
// assumes fixed-point values in a 16-bit signed format with 8 fraction bits
package fbreg_pkg;
  // ==================================================
  // widths and fixed-point format
  localparam int VAL_W = 16; // process values, signed, 8 fraction bits
  localparam int FRAC_W = 8; // fraction bits of values and gain
  localparam int GAIN_W = 12; // gain, unsigned, 8 fraction bits
  localparam logic signed [VAL_W-1:0] VAL_MAX = 16'sh7fff;
  localparam logic signed [VAL_W-1:0] VAL_MIN = -16'sh7fff - 16'sh0001;
  // gain limits: 0.00 .. 10.00, default 0.01 (rounded to 3/256)
  localparam logic [GAIN_W-1:0] GAIN_MAX = 12'ha00;
  localparam logic [GAIN_W-1:0] GAIN_RST = 12'h003;
  // ==================================================
  // selector codes
  localparam logic SHAPE_LINEAR = 1'b0;
  localparam logic SHAPE_SQRT = 1'b1;
  localparam logic [2:0] CMB_MIN = 3'h0;
  localparam logic [2:0] CMB_MAX = 3'h1;
  localparam logic [2:0] CMB_SUM = 3'h2;
  localparam logic [2:0] CMB_DIFF = 3'h3;
  localparam logic [2:0] CMB_AVG = 3'h4;
  localparam logic [2:0] CMB_ZLOW = 3'h5;
  localparam logic [2:0] CMB_ZHIGH = 3'h6;
  localparam logic [2:0] CMB_RST = CMB_MAX;
  localparam logic DIR_NORMAL = 1'b0;
  localparam logic CFG_CLOSED = 1'b1;
  // ==================================================
  // reset values
  localparam logic signed [VAL_W-1:0] SETPOINT_RST = 16'sh0000;
  localparam logic signed [VAL_W-1:0] FREQ_RST = 16'sh0000;
  // loop phase, one-hot
  typedef enum logic [2:0] {
    PH_IDLE = 3'b001,
    PH_RAMP = 3'b010,
    PH_CLOSED = 3'b100
  } phase_e;
endpackage : fbreg_pkg

// *** plant_model.sv ***
// far-side model: ramp generator and motor output stage beside the regulator
// assumes ctl_tick comes from the bench and frequency_demand from the regulator
`timescale 1ns/100ps
module plant_model
  import fbreg_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic ctl_tick,
  input wire logic start_cmd,
  input wire logic signed [VAL_W-1:0] frequency_demand,
  output logic signed [VAL_W-1:0] ramp_frequency,
  output logic signed [VAL_W-1:0] actual_frequency
);
  // ==================================================
  // ramp and motor
  // ramp climbs one step a tick while running; no wrap guard, so keep runs short
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ramp_frequency <= FREQ_RST;
      actual_frequency <= FREQ_RST;
    end else begin
      actual_frequency <= frequency_demand; // motor lags demand by one cycle
      if (!start_cmd) begin
        ramp_frequency <= FREQ_RST; // stopped: ramp falls back to zero
      end else if (ctl_tick) begin
        ramp_frequency <= ramp_frequency + 16'sh0040;
      end
    end
  end
endmodule : plant_model

// *** process_feedback_pid_setup_tb.sv ***
// self-checking bench for the regulator front end with the plant model
// assumes a free tick every second cycle and inputs changed at falling edges
`timescale 1ns/100ps
module process_feedback_pid_setup_tb;
  import fbreg_pkg::*;
  // ==================================================
  // stimulus and observed signals
  logic sys_clk = 1'b0, rstn = 1'b0, ctl_tick = 1'b0, loop_closed_cfg = 1'b1, start_cmd = 1'b0;
  logic feedback_shaping_select = 1'b0, regulator_direction = 1'b0;
  logic integrator_clamp_enable = 1'b1, current_limit = 1'b0, voltage_limit = 1'b0;
  logic frequency_limit = 1'b0, regulator_active;
  logic [2:0] dual_input_combine_mode = CMB_MAX;
  logic [GAIN_W-1:0] proportional_factor = 12'h100; // unity gain keeps the math plain
  logic signed [VAL_W-1:0] bus_feedback_one = 16'sh0100, bus_feedback_two = 16'sh0080;
  logic signed [VAL_W-1:0] analog_feedback_one = 16'sh0200, analog_feedback_two = 16'sh0400;
  logic signed [VAL_W-1:0] setpoint_one = 16'sh0500, setpoint_two = 16'sh0200;
  logic signed [VAL_W-1:0] ref_min = 16'sh0000, ref_max = 16'sh1000;
  logic signed [VAL_W-1:0] remote_reference = 16'sh0010, loop_entry_frequency = 16'sh0100;
  logic signed [VAL_W-1:0] ramp_frequency, actual_frequency, feedback_value;
  logic signed [VAL_W-1:0] resulting_reference, deviation, prop_term, frequency_demand;
  int err_count = 0, samples_checked = 0, i;
  // expected feedback per mode with channels 0x0300 and 0x0480
  logic [2:0] m_tab [5] = '{CMB_MIN, CMB_MAX, CMB_SUM, CMB_DIFF, CMB_AVG};
  logic [15:0] f_tab [5] = '{16'h0300, 16'h0480, 16'h0780, 16'h0180, 16'h03c0};
  // ==================================================
  // clock, tick and instances
  always #25 sys_clk = ~sys_clk;
  always @(negedge sys_clk) ctl_tick <= ~ctl_tick; // tick every second cycle
  fbreg_core i_dut (.sys_clk, .rstn, .ctl_tick, .loop_closed_cfg, .start_cmd,
    .feedback_shaping_select, .dual_input_combine_mode, .regulator_direction,
    .integrator_clamp_enable, .loop_entry_frequency, .proportional_factor, .bus_feedback_one,
    .bus_feedback_two, .analog_feedback_one, .analog_feedback_two, .setpoint_one,
    .setpoint_two, .ref_min, .ref_max, .remote_reference, .ramp_frequency, .actual_frequency,
    .current_limit, .voltage_limit, .frequency_limit, .feedback_value, .resulting_reference,
    .deviation, .prop_term, .frequency_demand, .regulator_active);
  plant_model i_plant (.sys_clk, .rstn, .ctl_tick, .start_cmd, .frequency_demand,
    .ramp_frequency, .actual_frequency);
  // ==================================================
  // shared tasks
  task test_done;
    if (err_count == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done
  task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // three ticks: one to take the change, one to register it, one spare
  task settle;
    repeat (6) @(negedge sys_clk);
  endtask : settle
  // bounded wait for the regulator to engage; running out is a mismatch
  task wait_active;
    int n;
    n = 0;
    while (regulator_active !== 1'b1 && n < 40) begin
      @(negedge sys_clk);
      n++;
    end
    if (n == 40) begin
      err_count++;
      $display("CHECK FAILED regulator_active expected 1 seen %b", regulator_active);
      test_done;
    end
  endtask : wait_active
  // ==================================================
  // scenarios
  task t_combine;
    for (i = 0; i < 5; i++) begin
      dual_input_combine_mode = m_tab[i];
      settle;
      chk("feedback", f_tab[i], feedback_value);
      chk("reference", 16'h0510, resulting_reference);
    end
    dual_input_combine_mode = 3'h7; // code outside the range keeps average
    settle;
    chk("refused mode", 16'h03c0, feedback_value);
  endtask : t_combine
  task t_zone;
    dual_input_combine_mode = CMB_ZLOW;
    settle;
    chk("zone low ref", 16'h0510, resulting_reference);
    chk("zone low dev", 16'h0210, deviation);
    dual_input_combine_mode = CMB_ZHIGH;
    settle;
    chk("zone high ref", 16'h0210, resulting_reference);
    chk("zone high dev", 16'hfd90, deviation);
    loop_closed_cfg = 1'b0; // open loop must fall back to setpoint one
    settle;
    chk("zone open ref", 16'h0510, resulting_reference);
    loop_closed_cfg = CFG_CLOSED;
  endtask : t_zone
  task t_shape;
    dual_input_combine_mode = CMB_MAX;
    settle; // leave the zone mode before square root is switched on
    feedback_shaping_select = SHAPE_SQRT;
    {bus_feedback_one, analog_feedback_one} = {16'sh0000, 16'sh0400};
    {bus_feedback_two, analog_feedback_two} = {16'sh0000, 16'sh0100};
    settle;
    chk("sqrt feedback", 16'h0200, feedback_value);
    feedback_shaping_select = SHAPE_LINEAR;
    {bus_feedback_one, analog_feedback_one} = {16'sh0100, 16'sh0200};
    {bus_feedback_two, analog_feedback_two} = {16'sh0080, 16'sh0400};
    setpoint_one = 16'sh2000;
    settle;
    chk("clamp high", 16'h1010, resulting_reference);
    setpoint_one = -16'sh0100;
    settle;
    chk("clamp low", 16'h0010, resulting_reference);
    setpoint_one = 16'sh0500;
  endtask : t_shape
  task t_direction;
    dual_input_combine_mode = CMB_MIN;
    regulator_direction = 1'b1;
    settle;
    chk("inverse dev", 16'hfdf0, deviation);
    loop_closed_cfg = 1'b0; // open loop ignores the direction setting
    settle;
    chk("open dev", 16'h0210, deviation);
    {loop_closed_cfg, regulator_direction} = {CFG_CLOSED, DIR_NORMAL};
    settle;
    chk("normal dev", 16'h0210, deviation);
  endtask : t_direction
  task t_start;
    current_limit = 1'b1;
    start_cmd = 1'b1;
    repeat (30) @(negedge sys_clk);
    chk("blocked", 16'h0000, {15'h0, regulator_active});
    current_limit = 1'b0;
    wait_active;
    proportional_factor = 12'h200;
    settle;
    chk("prop term", 16'h0420, prop_term);
    frequency_limit = 1'b1;
    settle;
    chk("clamped", 16'h0000, {15'h0, regulator_active});
    frequency_limit = 1'b0;
    settle;
    chk("still held", 16'h0000, {15'h0, regulator_active});
    setpoint_one = 16'sh0000; // deviation turns negative
    wait_active;
    integrator_clamp_enable = 1'b0;
    voltage_limit = 1'b1;
    settle;
    chk("no clamp", 16'h0001, {15'h0, regulator_active});
    start_cmd = 1'b0;
    settle;
    chk("stop demand", 16'h0000, frequency_demand);
  endtask : t_start
  // ==================================================
  // main sequence
  initial begin
    repeat (12) @(negedge sys_clk);
    rstn = 1'b1;
    t_combine;
    t_zone;
    t_shape;
    t_direction;
    t_start;
    test_done;
  end
endmodule : process_feedback_pid_setup_tb
